//--- pkg/pec_pkg.sv
package pec_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] OFS_SEL0    = 4'h0;
  localparam logic [3:0] OFS_SEL1    = 4'h1;
  localparam logic [3:0] OFS_CNT0_LO = 4'h2;
  localparam logic [3:0] OFS_CNT0_HI = 4'h3;
  localparam logic [3:0] OFS_CNT1_LO = 4'h4;
  localparam logic [3:0] OFS_CNT1_HI = 4'h5;
  localparam logic [3:0] OFS_STATUS  = 4'h6;

  // Event select field layout
  localparam int SEL_EVT_LSB  = 0;
  localparam int SEL_MSK_LSB  = 8;
  localparam int SEL_PIN_CTRL = 19;
  localparam int SEL_ENABLE   = 22;
  localparam logic [31:0] SEL_RESET = 32'h0000_0000;

  // Unit mask bits
  localparam int MSK_ANY_AGENT = 5;
  localparam logic [3:0] MESI_MOD = 4'h8;
  localparam logic [3:0] MESI_EXC = 4'h4;
  localparam logic [3:0] MESI_SHR = 4'h2;
  localparam logic [3:0] MESI_INV = 4'h1;

  // Cache line state encoding on the event inputs
  localparam logic [1:0] ST_INV = 2'h0;
  localparam logic [1:0] ST_SHR = 2'h1;
  localparam logic [1:0] ST_EXC = 2'h2;
  localparam logic [1:0] ST_MOD = 2'h3;

  // Event codes
  localparam logic [7:0] EV_LOAD_BLOCK     = 8'h03;
  localparam logic [7:0] EV_SB_DRAIN       = 8'h04;
  localparam logic [7:0] EV_MISALIGN       = 8'h05;
  localparam logic [7:0] EV_FP_EXEC        = 8'h10;
  localparam logic [7:0] EV_FP_MICROCODE_ASSIST_EVENT      = 8'h11;
  localparam logic [7:0] EV_MULTIPLY       = 8'h12;
  localparam logic [7:0] EV_DIVIDE         = 8'h13;
  localparam logic [7:0] EV_DIV_BUSY       = 8'h14;
  localparam logic [7:0] EV_SL_STROBE      = 8'h21;
  localparam logic [7:0] EV_SL_DBUS_BUSY   = 8'h22;
  localparam logic [7:0] EV_SL_READ_BUSY   = 8'h23;
  localparam logic [7:0] EV_SL_ALLOC       = 8'h24;
  localparam logic [7:0] EV_SL_MOD_ALLOC   = 8'h25;
  localparam logic [7:0] EV_SL_EVICT       = 8'h26;
  localparam logic [7:0] EV_SL_MOD_EVICT   = 8'h27;
  localparam logic [7:0] EV_SL_STORE       = 8'h2A;
  localparam logic [7:0] EV_SL_REQUEST     = 8'h2E;
  localparam logic [7:0] EV_BUS_REQ_OUT    = 8'h60;
  localparam logic [7:0] EV_BLOCK_NEXT     = 8'h61;
  localparam logic [7:0] EV_DATA_READY     = 8'h62;
  localparam logic [7:0] EV_BUS_LOCK       = 8'h63;
  localparam logic [7:0] EV_DATA_RECV      = 8'h64;
  localparam logic [7:0] EV_BURST_READ     = 8'h65;
  localparam logic [7:0] EV_OWN_READ       = 8'h66;
  localparam logic [7:0] EV_WRITEBACK      = 8'h67;
  localparam logic [7:0] EV_IO_TXN         = 8'h6C;
  localparam logic [7:0] EV_MEM_TXN        = 8'h6F;
  localparam logic [7:0] EV_ANY_TXN        = 8'h70;
  localparam logic [7:0] EV_SNOOP_HIT      = 8'h7A;
  localparam logic [7:0] EV_SNOOP_HIT_MOD  = 8'h7B;
  localparam logic [7:0] EV_SNOOP_STALL    = 8'h7E;
  localparam logic [7:0] EV_FP_RETIRED     = 8'hC1;

  // Core to bus clock ratio codes
  localparam logic [2:0] RATIO_2_TO_1 = 3'h2;
  localparam logic [2:0] RATIO_3_TO_1 = 3'h3;

  localparam int REQ_W = 4;

endpackage

//--- pkg/pec_evt_if.sv
`timescale 1ns/1ps
interface pec_evt_if #(parameter int REQ_W = 4);
  logic [31:0]      sel;
  logic             bus_tick;
  logic [REQ_W-1:0] req_out;
  logic [31:0]      ev;
  logic             hit;
  logic [REQ_W-1:0] add;
  modport src (output sel, bus_tick, req_out, ev);
  modport cnt (input sel, bus_tick, req_out, ev, output hit, add);
endinterface

//--- rtl/pec_sel.sv
`timescale 1ns/1ps
module pec_sel #(
  parameter int IS_CTR1 = 0
) (
  pec_evt_if.cnt e
);
  logic [7:0] code;
  logic [7:0] unit_qualifier_mask;
  logic       any_ok;
  assign code = e.sel[pec_pkg::SEL_MSK_LSB-1:pec_pkg::SEL_EVT_LSB];
  assign unit_qualifier_mask = e.sel[pec_pkg::SEL_MSK_LSB+7:pec_pkg::SEL_MSK_LSB];
  assign any_ok = unit_qualifier_mask[pec_pkg::MSK_ANY_AGENT];

  always_comb begin
    e.hit = 1'b0;
    e.add = '0;
    case (code)
      pec_pkg::EV_SL_STORE:      e.hit = e.ev[0];
      pec_pkg::EV_SL_REQUEST:    e.hit = e.ev[1];
      pec_pkg::EV_SL_ALLOC:      e.hit = e.ev[2];
      pec_pkg::EV_SL_MOD_ALLOC:  e.hit = e.ev[3];
      pec_pkg::EV_SL_EVICT:      e.hit = e.ev[4];
      pec_pkg::EV_SL_MOD_EVICT:  e.hit = e.ev[5];
      pec_pkg::EV_SL_STROBE:     e.hit = e.ev[6];
      pec_pkg::EV_SL_DBUS_BUSY:  e.hit = e.ev[7];
      pec_pkg::EV_SL_READ_BUSY:  e.hit = e.ev[8];
      pec_pkg::EV_DATA_READY:    e.hit = any_ok ? e.ev[10]
                                               : e.ev[9] & e.bus_tick;
      pec_pkg::EV_BUS_LOCK:      e.hit = e.ev[11];
      pec_pkg::EV_BUS_REQ_OUT:   e.add = e.req_out;
      pec_pkg::EV_BURST_READ:    e.hit = any_ok ? e.ev[13] : e.ev[12];
      pec_pkg::EV_OWN_READ:      e.hit = any_ok ? e.ev[15] : e.ev[14];
      pec_pkg::EV_WRITEBACK:     e.hit = any_ok ? e.ev[17] : e.ev[16];
      pec_pkg::EV_IO_TXN:        e.hit = any_ok ? e.ev[19] : e.ev[18];
      pec_pkg::EV_MEM_TXN:       e.hit = any_ok ? e.ev[21] : e.ev[20];
      pec_pkg::EV_ANY_TXN:       e.hit = any_ok ? e.ev[23] : e.ev[22];
      pec_pkg::EV_DATA_RECV:     e.hit = e.ev[24] & e.bus_tick;
      pec_pkg::EV_BLOCK_NEXT:    e.hit = e.ev[25] & e.bus_tick;
      pec_pkg::EV_SNOOP_HIT:     e.hit = e.ev[26] & e.bus_tick;
      pec_pkg::EV_SNOOP_HIT_MOD: e.hit = e.ev[27] & e.bus_tick;
      pec_pkg::EV_SNOOP_STALL:   e.hit = e.ev[28];
      pec_pkg::EV_FP_RETIRED:    e.hit = (IS_CTR1 == 0) & e.ev[29];
      pec_pkg::EV_FP_EXEC:       e.hit = (IS_CTR1 == 0) & e.ev[30];
      pec_pkg::EV_DIV_BUSY:      e.hit = (IS_CTR1 == 0) & e.ev[31];
      default:                   e.hit = 1'b0;
    endcase
  end
endmodule

//--- rtl/pec_top.sv
`timescale 1ns/1ps
// What this block does
// - Code 2AH counts qualified second-level stores
// - Store count keeps TLB misses, drops uncacheable
// - Codes 24H-27H count line allocs and evictions
// - 2EH counts requests, 21H counts address strobes
// - 22H data bus busy, 23H read busy
// - 62H self bus clocks, any processor clocks
// - 63H counts lock cycles in processor clocks
// - 60H adds outstanding full-line reads per cycle
// - 65H-67H count completed bus transactions
// - 6CH IO, 6FH memory, 70H all transactions
// - 64H receive, 61H block-next drive, bus clocks
// - 7AH/7BH snoop pin drive, 7EH snoop stall
// - Pin control set, ratio 2 or 3: pulse
// - Pin control clear toggles; other ratios idle
// - C1H retired FP ops, counter 0 only
// - 10H executed FP ops, counter 0 only
// - 11H FP microcode assists, counter 1 only
// - 12H/13H multiplies, divides, counter 1 only
// - 14H divider busy cycles, counter 0 only
// - 03H counts store-buffer blocked loads
// - 04H counts store buffer drain cycles
// - 05H counts misaligned micro-op dispatch cycles
// - Unit mask low bits select line states
// - Unit mask bit 5 selects self or any
module pec_top #(
  parameter int CNT_W = 40,
  parameter int REQ_W = pec_pkg::REQ_W
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             resetn_i,
  // Register port
  input  wire logic [3:0]       reg_addr_i,
  input  wire logic [31:0]      reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic      [31:0]      reg_rdata_o,
  // Bus clock phase and ratio
  input  wire logic             bus_tick_i,
  input  wire logic [2:0]       clk_ratio_i,
  // Second-level cache events
  input  wire logic             sl_store_i,
  input  wire logic             sl_store_cacheable_i,
  input  wire logic             sl_request_i,
  input  wire logic [1:0]       sl_line_state_i,
  input  wire logic             second_level_alloc_event_i,
  input  wire logic             second_level_mod_alloc_event_i,
  input  wire logic             second_level_evict_event_i,
  input  wire logic             second_level_mod_evict_event_i,
  input  wire logic             second_level_strobe_event_i,
  input  wire logic             second_level_databus_busy_event_i,
  input  wire logic             second_level_read_busy_event_i,
  // External bus events
  input  wire logic             data_ready_pin_self_i,
  input  wire logic             data_ready_pin_any_i,
  input  wire logic             bus_lock_i,
  input  wire logic [REQ_W-1:0] bus_req_outstanding_i,
  input  wire logic [5:0]       txn_done_self_i,
  input  wire logic [5:0]       txn_done_any_i,
  input  wire logic             data_receive_event_i,
  input  wire logic             block_next_request_pin_i,
  input  wire logic             snoop_hit_pin_i,
  input  wire logic             snoop_hit_modified_pin_i,
  input  wire logic             snoop_stall_i,
  // Floating point and divider events
  input  wire logic             fp_retired_ops_event_i,
  input  wire logic             fp_executed_ops_event_i,
  input  wire logic             fp_microcode_assist_event_i,
  input  wire logic             multiply_event_i,
  input  wire logic             divide_event_i,
  input  wire logic             divider_busy_i,
  // Memory ordering events
  input  wire logic             load_block_event_i,
  input  wire logic             store_buffer_drain_event_i,
  input  wire logic             misaligned_access_event_i,
  // Breakpoint monitor pins and overflow
  output logic      [1:0]       breakpoint_monitor_pins_o,
  output logic      [1:0]       overflow_o
);

  if (CNT_W < 33 || CNT_W > 64) begin : g_bad_cnt_w
    $error("CNT_W must be 33..64");
  end
  if (REQ_W < 1 || REQ_W > 8) begin : g_bad_req_w
    $error("REQ_W must be 1..8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event select registers
  logic [31:0]      event_select_zero_ff;
  logic [31:0]      event_select_one_ff;
  logic [CNT_W-1:0] cnt_ff [2];
  logic [1:0]       ovf_sticky_ff;
  logic [1:0]       ovf_pulse;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      event_select_zero_ff <= pec_pkg::SEL_RESET;
      event_select_one_ff  <= pec_pkg::SEL_RESET;
    end else if (reg_wr_i) begin
      // Unlisted codes are stored as written; they count nothing
      if (reg_addr_i == pec_pkg::OFS_SEL0) event_select_zero_ff <= reg_wdata_i;
      if (reg_addr_i == pec_pkg::OFS_SEL1) event_select_one_ff  <= reg_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State qualification for second-level cache events
  logic [3:0] state_bit;
  always_comb begin
    case (sl_line_state_i)
      pec_pkg::ST_MOD: state_bit = pec_pkg::MESI_MOD;
      pec_pkg::ST_EXC: state_bit = pec_pkg::MESI_EXC;
      pec_pkg::ST_SHR: state_bit = pec_pkg::MESI_SHR;
      default:         state_bit = pec_pkg::MESI_INV;
    endcase
  end

  logic [31:0] sel_w [2];
  assign sel_w[0] = event_select_zero_ff;
  assign sel_w[1] = event_select_one_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Per-counter selection and counting
  logic [1:0] hit_w;
  logic [REQ_W-1:0] add_w [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ctr
      pec_evt_if #(.REQ_W(REQ_W)) ei ();
      logic [3:0]  mesi;
      logic        en;
      logic        extra;
      logic [31:0] ev;
      assign mesi = sel_w[g][pec_pkg::SEL_MSK_LSB+3:pec_pkg::SEL_MSK_LSB];
      assign en   = sel_w[g][pec_pkg::SEL_ENABLE];
      always_comb begin
        ev     = '0;
        // Only cacheable stores count; zero mask counts nothing
        ev[0]  = sl_store_i & sl_store_cacheable_i & |(mesi & state_bit);
        ev[1]  = sl_request_i & |(mesi & state_bit);
        ev[2]  = second_level_alloc_event_i;
        ev[3]  = second_level_mod_alloc_event_i;
        ev[4]  = second_level_evict_event_i;
        ev[5]  = second_level_mod_evict_event_i;
        ev[6]  = second_level_strobe_event_i;
        ev[7]  = second_level_databus_busy_event_i;
        ev[8]  = second_level_read_busy_event_i;
        ev[9]  = data_ready_pin_self_i;
        ev[10] = data_ready_pin_any_i;
        ev[11] = bus_lock_i;
        ev[12] = txn_done_self_i[0];
        ev[13] = txn_done_any_i[0];
        ev[14] = txn_done_self_i[1];
        ev[15] = txn_done_any_i[1];
        ev[16] = txn_done_self_i[2];
        ev[17] = txn_done_any_i[2];
        ev[18] = txn_done_self_i[3];
        ev[19] = txn_done_any_i[3];
        ev[20] = txn_done_self_i[4];
        ev[21] = txn_done_any_i[4];
        ev[22] = txn_done_self_i[5];
        ev[23] = txn_done_any_i[5];
        ev[24] = data_receive_event_i;
        ev[25] = block_next_request_pin_i;
        ev[26] = snoop_hit_pin_i;
        ev[27] = snoop_hit_modified_pin_i;
        ev[28] = snoop_stall_i;
        ev[29] = fp_retired_ops_event_i;
        ev[30] = fp_executed_ops_event_i;
        ev[31] = divider_busy_i;
      end
      assign ei.sel      = sel_w[g];
      assign ei.bus_tick = bus_tick_i;
      assign ei.req_out  = bus_req_outstanding_i;
      assign ei.ev       = ev;
      pec_sel #(.IS_CTR1(g)) u_sel (.e(ei.cnt));

      // Events outside the shared decoder
      always_comb begin
        case (sel_w[g][pec_pkg::SEL_MSK_LSB-1:pec_pkg::SEL_EVT_LSB])
          pec_pkg::EV_FP_MICROCODE_ASSIST_EVENT: extra = (g == 1) & fp_microcode_assist_event_i;
          pec_pkg::EV_MULTIPLY:  extra = (g == 1) & multiply_event_i;
          pec_pkg::EV_DIVIDE:    extra = (g == 1) & divide_event_i;
          pec_pkg::EV_LOAD_BLOCK: extra = load_block_event_i;
          pec_pkg::EV_SB_DRAIN:  extra = store_buffer_drain_event_i;
          pec_pkg::EV_MISALIGN:  extra = misaligned_access_event_i;
          default:               extra = 1'b0;
        endcase
      end
      assign hit_w[g] = en & (ei.hit | extra);
      assign add_w[g] = en ? ei.add : '0;

      logic [CNT_W:0] sum;
      logic           wr_lo;
      logic           wr_hi;
      assign sum = {1'b0, cnt_ff[g]} + CNT_W'(add_w[g]) + CNT_W'(hit_w[g]);
      assign wr_lo = reg_wr_i && reg_addr_i == 4'(pec_pkg::OFS_CNT0_LO + 2 * g);
      assign wr_hi = reg_wr_i && reg_addr_i == 4'(pec_pkg::OFS_CNT0_HI + 2 * g);
      // Carry out of the top bit marks the wrap; a counter write drops it
      assign ovf_pulse[g] = sum[CNT_W] & ~(wr_lo | wr_hi);

      always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          cnt_ff[g] <= '0;
        end else if (wr_lo) begin
          cnt_ff[g] <= {cnt_ff[g][CNT_W-1:32], reg_wdata_i};
        end else if (wr_hi) begin
          cnt_ff[g] <= {reg_wdata_i[CNT_W-33:0], cnt_ff[g][31:0]};
        end else begin
          cnt_ff[g] <= sum[CNT_W-1:0];
        end
      end

      // Breakpoint monitor pin: pulse or toggle on overflow
      logic ratio_ok;
      assign ratio_ok = (clk_ratio_i == pec_pkg::RATIO_2_TO_1) ||
                        (clk_ratio_i == pec_pkg::RATIO_3_TO_1);
      always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          breakpoint_monitor_pins_o[g] <= 1'b0;
        end else if (sel_w[g][pec_pkg::SEL_PIN_CTRL]) begin
          breakpoint_monitor_pins_o[g] <= ovf_pulse[g] & ratio_ok;
        end else if (ovf_pulse[g] & ratio_ok) begin
          breakpoint_monitor_pins_o[g] <= ~breakpoint_monitor_pins_o[g];
        end
      end

      always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          overflow_o[g] <= 1'b0;
        end else begin
          overflow_o[g] <= ovf_pulse[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Sticky overflow status; a new overflow wins over a clear
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ovf_sticky_ff <= 2'h0;
    end else if (reg_wr_i && reg_addr_i == pec_pkg::OFS_STATUS) begin
      ovf_sticky_ff <= (ovf_sticky_ff & ~reg_wdata_i[1:0]) | ovf_pulse;
    end else begin
      ovf_sticky_ff <= ovf_sticky_ff | ovf_pulse;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the read strobe
  logic [63:0] c0_ext;
  logic [63:0] c1_ext;
  assign c0_ext = 64'(cnt_ff[0]);
  assign c1_ext = 64'(cnt_ff[1]);

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        pec_pkg::OFS_SEL0:    reg_rdata_o <= event_select_zero_ff;
        pec_pkg::OFS_SEL1:    reg_rdata_o <= event_select_one_ff;
        pec_pkg::OFS_CNT0_LO: reg_rdata_o <= c0_ext[31:0];
        pec_pkg::OFS_CNT0_HI: reg_rdata_o <= c0_ext[63:32];
        pec_pkg::OFS_CNT1_LO: reg_rdata_o <= c1_ext[31:0];
        pec_pkg::OFS_CNT1_HI: reg_rdata_o <= c1_ext[63:32];
        pec_pkg::OFS_STATUS:  reg_rdata_o <= {30'h0000_0000, ovf_sticky_ff};
        default:              reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

endmodule

//--- test/pec_top_properties.sv
`timescale 1ns/1ps
module pec_top_checker (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  // Register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [31:0] reg_rdata_o,
  // Ratio and pins
  input  wire logic [2:0]  clk_ratio_i,
  input  wire logic [1:0]  breakpoint_monitor_pins_o,
  input  wire logic [1:0]  overflow_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic ratio_ok;
  assign ratio_ok = (clk_ratio_i == pec_pkg::RATIO_2_TO_1) ||
                    (clk_ratio_i == pec_pkg::RATIO_3_TO_1);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_status_clear;
    reg_wr_i && reg_addr_i == pec_pkg::OFS_STATUS && reg_wdata_i[1:0] == 2'h3 && overflow_o == 2'h0
      ##1 !reg_wr_i && overflow_o == 2'h0
      ##1 reg_rd_i && reg_addr_i == pec_pkg::OFS_STATUS && overflow_o == 2'h0;
  endsequence
  sequence s_ratio_off;
    !ratio_ok [*3];
  endsequence
  property p_rdata_idle;
    !reg_rd_i |=> reg_rdata_o == 32'h0;
  endproperty
  property p_unmapped;
    reg_rd_i && reg_addr_i > pec_pkg::OFS_STATUS |=> reg_rdata_o == 32'h0;
  endproperty
  property p_ovf0_pulse;
    overflow_o[0] |=> !overflow_o[0];
  endproperty
  property p_ovf1_pulse;
    overflow_o[1] |=> !overflow_o[1];
  endproperty
  property p_pin0_cause;
    $changed(breakpoint_monitor_pins_o[0]) |-> overflow_o[0] || $past(overflow_o[0]);
  endproperty
  property p_pin1_cause;
    $changed(breakpoint_monitor_pins_o[1]) |-> overflow_o[1] || $past(overflow_o[1]);
  endproperty
  property p_pin_idle;
    s_ratio_off |-> $stable(breakpoint_monitor_pins_o);
  endproperty
  property p_reset_quiet;
    $rose(resetn_i) |-> overflow_o == 2'h0 && breakpoint_monitor_pins_o == 2'h0;
  endproperty
  property p_status_clear;
    s_status_clear |=> reg_rdata_o[1:0] == 2'h0;
  endproperty
  ////////////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data standing without a read");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read returned data");
  a_ovf0_pulse: assert property (p_ovf0_pulse)
    else $error("overflow 0 longer than one cycle");
  a_ovf1_pulse: assert property (p_ovf1_pulse)
    else $error("overflow 1 longer than one cycle");
  a_pin0_cause: assert property (p_pin0_cause)
    else $error("monitor pin 0 moved without overflow");
  a_pin1_cause: assert property (p_pin1_cause)
    else $error("monitor pin 1 moved without overflow");
  a_pin_idle: assert property (p_pin_idle)
    else $error("monitor pins moved at unsupported ratio");
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active after reset");
  a_status_clear: assert property (p_status_clear)
    else $error("overflow status not cleared");
endmodule

bind pec_top pec_top_checker u_pec_top_checker (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .clk_ratio_i(clk_ratio_i),
  .breakpoint_monitor_pins_o(breakpoint_monitor_pins_o), .overflow_o(overflow_o));

//--- test/pec_core_model.sv
`timescale 1ns/1ps
module pec_core_model (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  // Commands from the bench
  input  wire logic [31:0] ev_i,
  input  wire logic        any_only_i,
  input  wire logic        uncached_i,
  // Event sources
  output logic      [31:0] ev_o,
  output logic      [5:0]  txn_any_o,
  output logic             cacheable_o,
  output logic             bus_tick_o
);
  logic tick_ff;
  // Bus clock at half the core rate
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= ~tick_ff;
    end
  end
  assign bus_tick_o = tick_ff;
  // Transactions complete as single-cycle pulses; another agent's never reach self
  assign ev_o = {ev_i[31:26] & {6{tick_ff & !any_only_i}}, ev_i[25:11],
                 ev_i[10] | ev_i[9], ev_i[9:0]};
  assign txn_any_o   = ev_i[31:26] & {6{tick_ff}};
  assign cacheable_o = !uncached_i;
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
  logic                      ref_clk_i, resetn_i, reg_wr_i, reg_rd_i, any_only, uncached;
  logic                      cacheable, tick;
  logic [3:0]                reg_addr_i;
  logic [31:0]               reg_wdata_i, reg_rdata_o, ev, evp, rd;
  logic [2:0]                clk_ratio_i;
  logic [5:0]                txn_any;
  logic [1:0]                bpm, ovf;
  logic [pec_pkg::REQ_W-1:0] req;
  int                        bad_count, check_count, cycles;
  // Code, mask, flags (event bit, any-only, uncached, counter 1), expected count
  logic [31:0] tbl [40] = '{
    32'h2A0F0008, 32'h2A070000, 32'h2A0F4000, 32'h2E0F0108,
    32'h24000208, 32'h25000308, 32'h26000408, 32'h27000508,
    32'h21000608, 32'h22000708, 32'h23000808, 32'h62000904,
    32'h62200A08, 32'h63000B08, 32'h63200B08, 32'h64000C04,
    32'h61000D04, 32'h7A000E04, 32'h7B000F04, 32'h7E001008,
    32'hC1001108, 32'hC1009100, 32'h10001208, 32'h11009308,
    32'h11001300, 32'h12009408, 32'h13009508, 32'h14001608,
    32'h03001708, 32'h04001808, 32'h05001908, 32'h65001A04,
    32'h66001B04, 32'h67001C04, 32'h6C001D04, 32'h6F001E04,
    32'h70001F04, 32'h65003A00, 32'h65203A04, 32'h60000018};

  pec_core_model u_pec_core_model (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ev_i(ev),
    .any_only_i(any_only), .uncached_i(uncached), .ev_o(evp), .txn_any_o(txn_any),
    .cacheable_o(cacheable), .bus_tick_o(tick));
  pec_top u_pec_top (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .bus_tick_i(tick), .clk_ratio_i(clk_ratio_i),
    .sl_store_i(evp[0]), .sl_store_cacheable_i(cacheable), .sl_request_i(evp[1]),
    .sl_line_state_i(pec_pkg::ST_MOD), .second_level_alloc_event_i(evp[2]),
    .second_level_mod_alloc_event_i(evp[3]), .second_level_evict_event_i(evp[4]),
    .second_level_mod_evict_event_i(evp[5]), .second_level_strobe_event_i(evp[6]),
    .second_level_databus_busy_event_i(evp[7]), .second_level_read_busy_event_i(evp[8]),
    .data_ready_pin_self_i(evp[9]), .data_ready_pin_any_i(evp[10]), .bus_lock_i(evp[11]),
    .bus_req_outstanding_i(req), .txn_done_self_i(evp[31:26]), .txn_done_any_i(txn_any),
    .data_receive_event_i(evp[12]), .block_next_request_pin_i(evp[13]),
    .snoop_hit_pin_i(evp[14]), .snoop_hit_modified_pin_i(evp[15]), .snoop_stall_i(evp[16]),
    .fp_retired_ops_event_i(evp[17]), .fp_executed_ops_event_i(evp[18]),
    .fp_microcode_assist_event_i(evp[19]), .multiply_event_i(evp[20]),
    .divide_event_i(evp[21]), .divider_busy_i(evp[22]), .load_block_event_i(evp[23]),
    .store_buffer_drain_event_i(evp[24]), .misaligned_access_event_i(evp[25]),
    .breakpoint_monitor_pins_o(bpm), .overflow_o(ovf));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (bad_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Called at a rising edge; returns at a rising edge after one idle cycle
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic reg_read(input logic [3:0] a);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    rd = reg_rdata_o;
    @(posedge ref_clk_i);
  endtask

  task automatic run_case(input logic [31:0] t);
    logic [3:0] sel;
    logic [3:0] lo;
    sel = t[15] ? pec_pkg::OFS_SEL1 : pec_pkg::OFS_SEL0;
    lo  = t[15] ? pec_pkg::OFS_CNT1_LO : pec_pkg::OFS_CNT0_LO;
    reg_write(lo, 32'h0);
    reg_write(lo + 4'h1, 32'h0);
    reg_write(sel, 32'h0040_0000 | {16'h0, t[23:16], t[31:24]});
    ev       <= 32'h1 << t[12:8];
    any_only <= t[13];
    uncached <= t[14];
    req      <= (t[31:24] == pec_pkg::EV_BUS_REQ_OUT) ? 4'h3 : 4'h0;
    repeat (8) @(posedge ref_clk_i);
    ev       <= 32'h0;
    any_only <= 1'b0;
    uncached <= 1'b0;
    req      <= 4'h0;
    repeat (2) @(posedge ref_clk_i);
    reg_read(lo);
    check_val("event count", {24'h0, t[7:0]}, rd);
  endtask

  task automatic ovf_case(input int c, input logic pin_ctl, input logic ratio_on);
    logic       p0;
    logic [3:0] lo;
    int         n;
    p0 = bpm[c];
    lo = 4'(pec_pkg::OFS_CNT0_LO + 2 * c);
    reg_write(4'(pec_pkg::OFS_SEL0 + c), 32'h0040_0022 | (32'(pin_ctl) << 19));
    reg_write(lo, 32'hFFFF_FFFF);
    reg_write(lo + 4'h1, 32'h0000_00FF);
    ev <= 32'h80;
    @(posedge ref_clk_i);
    ev <= 32'h0;
    #1;
    n = 0;
    while (ovf[c] !== 1'b1 && n < 4) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    check_val("overflow", 32'h1, {31'h0, ovf[c]});
    check_val("pin", {31'h0, !ratio_on ? p0 : pin_ctl | ~p0}, {31'h0, bpm[c]});
    @(posedge ref_clk_i);
    #1;
    check_val("overflow end", 32'h0, {31'h0, ovf[c]});
    check_val("pin after", {31'h0, (!ratio_on || pin_ctl) ? p0 : ~p0}, {31'h0, bpm[c]});
    @(posedge ref_clk_i);
    reg_read(lo);
    check_val("wrapped count", 32'h0, rd);
    reg_read(lo + 4'h1);
    check_val("wrapped high", 32'h0, rd);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    resetn_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 32'h0;
    ev = 32'h0;
    any_only = 1'b0;
    uncached = 1'b0;
    req = 4'h0;
    clk_ratio_i = pec_pkg::RATIO_2_TO_1;
    repeat (6) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_write(4'h9, 32'h0040_0022);
    reg_read(pec_pkg::OFS_SEL0);
    check_val("select reset", pec_pkg::SEL_RESET, rd);
    reg_read(4'hF);
    check_val("unmapped", 32'h0, rd);
    foreach (tbl[i]) run_case(tbl[i]);
    ovf_case(0, 1'b1, 1'b1);
    ovf_case(0, 1'b0, 1'b1);
    ovf_case(1, 1'b1, 1'b1);
    clk_ratio_i <= 3'h5;
    @(posedge ref_clk_i);
    ovf_case(0, 1'b0, 1'b0);
    reg_read(pec_pkg::OFS_STATUS);
    check_val("status", 32'h3, rd);
    reg_write(pec_pkg::OFS_STATUS, 32'h3);
    reg_read(pec_pkg::OFS_STATUS);
    check_val("status cleared", 32'h0, rd);
    complete_run();
  end
endmodule
